// ---- design/cbm_pin_mux.sv ----
`timescale 1ns/1ps
// ==========================================================
// configurable control pin function mux
// ==========================================================
// Notes on behaviour
// - each pin's function comes from configuration memory
// - high impedance keeps the driver off
// - constant-high drives logic one
// - constant-low drives logic zero
// - rs485 enable high while serial data sends
// - power indicator low once configured, high suspended
// - tx led pulses low on usb transmit
// - rx led pulses low on usb receive
// - combined led pulses low on either
// - suspend indicator low while link suspended
// - clock options output 24, 12, 6 MHz
// - gpio option makes pin host bit-bang line
// - charger option high when charger detected
// - inverted charger option outputs the complement
// - write strobe option outputs bit-bang write strobe
// - read strobe option outputs bit-bang read strobe
// - bus power option senses pin as input
// - time stamp toggles per start-of-frame
// - keep-awake input low blocks suspend entry
// - clock outputs stop during suspend
// - defaults: rs485, rx led, tx led, suspend
module cbm_pin_mux
    import cbm_pkg::*;
#(
    parameter int LED_HOLD = LED_HOLD_CYC // activity led stretch, cycles
)
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,

    // configuration memory
    input wire logic config_valid,
    input wire logic [PIN_N-1:0][SEL_W-1:0] config_nvm_sel,

    // internal status from uart and usb engine
    input wire logic uart_tx_busy,
    input wire logic usb_configured,
    input wire logic usb_suspended,
    input wire logic usb_tx_active,
    input wire logic usb_rx_active,
    input wire logic usb_sof_pulse,
    input wire logic charger_detected,

    // bit-bang engine
    input wire logic parallel_write_strobe_n,
    input wire logic parallel_read_strobe_n,
    input wire logic [PIN_N-1:0] gpio_out,
    input wire logic [PIN_N-1:0] gpio_drive,

    // pads
    input wire logic [PIN_N-1:0] config_bus_pin_in,
    output logic [PIN_N-1:0] config_bus_pin_out,
    output logic [PIN_N-1:0] config_bus_pin_oe_n,

    // sensed inputs
    output logic [PIN_N-1:0] gpio_in,
    output logic bus_power_sense_in,
    output logic keep_awake_n
);

    // counter width and reload value
    localparam int HOLD_W = $clog2(LED_HOLD + 1);
    localparam logic [HOLD_W-1:0] HOLD_LOAD = HOLD_W'(LED_HOLD);

    // ==========================================================
    // input synchronisers
    // ==========================================================
    logic [PIN_N-1:0] pin_s1_q; // first stage, read only by second
    logic [PIN_N-1:0] pin_s2_q; // stable pad level

    // two flops on every pad input
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
        end
        else
        begin
            pin_s1_q <= config_bus_pin_in;
            pin_s2_q <= pin_s1_q;
        end
    end

    // ==========================================================
    // selection
    // ==========================================================
    logic [PIN_N-1:0][SEL_W-1:0] sel; // active selection per pin

    // memory setting, or defaults before it is loaded
    always_comb
    begin
        if (config_valid)
        begin
            sel = config_nvm_sel;
        end
        else
        begin
            sel[0] = DEF_SEL_0;
            sel[1] = DEF_SEL_1;
            sel[2] = DEF_SEL_2;
            sel[3] = DEF_SEL_3;
        end
    end

    // ==========================================================
    // clock outputs
    // ==========================================================
    cbm_clk_if clk_bus ();

    // clocks frozen low while suspended
    assign clk_bus.run = !usb_suspended;

    cbm_clk_gen u_clk_gen (
        .clock (clock),
        .rst_b (rst_b),
        .clk_bus (clk_bus.gen)
    );

    // ==========================================================
    // activity led stretchers: tx, rx, either
    // ==========================================================
    logic [2:0] led_act; // raw activity per led kind
    logic [2:0][HOLD_W-1:0] led_cnt_q; // remaining low time
    logic [2:0] led_n; // active-low led levels

    assign led_act = {usb_tx_active | usb_rx_active, usb_rx_active, usb_tx_active};

    // reload on activity so short bursts stay visible
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            led_cnt_q <= '0;
        end
        else
        begin
            for (int k = 0; k < 3; k++)
            begin
                if (led_act[k])
                begin
                    led_cnt_q[k] <= HOLD_LOAD;
                end
                else if (led_cnt_q[k] != '0)
                begin
                    led_cnt_q[k] <= led_cnt_q[k] - HOLD_W'(1);
                end
            end
        end
    end

    // low while active or stretching, high otherwise
    always_comb
    begin
        for (int k = 0; k < 3; k++)
        begin
            led_n[k] = !(led_act[k] || (led_cnt_q[k] != '0));
        end
    end

    // ==========================================================
    // time stamp
    // ==========================================================
    logic stamp_q; // toggles per start-of-frame

    // one toggle per received frame marker
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            stamp_q <= 1'b0;
        end
        else if (usb_sof_pulse)
        begin
            stamp_q <= ~stamp_q;
        end
    end

    // ==========================================================
    // per-pin function mux
    // ==========================================================
    logic [PIN_N-1:0] out_d; // next pad level
    logic [PIN_N-1:0] oe_n_d; // next driver enable, low drives
    logic power_on_n; // power switch indicator

    // high until configured and whenever suspended
    assign power_on_n = !(usb_configured && !usb_suspended);

    // choose source and driver state for each pin
    always_comb
    begin
        for (int i = 0; i < PIN_N; i++)
        begin
            out_d[i] = 1'b0;
            oe_n_d[i] = 1'b0; // output selections drive
            case (sel[i])
                // fixed levels
                SEL_TRISTATE: oe_n_d[i] = 1'b1;
                SEL_DRIVE1: out_d[i] = 1'b1;
                SEL_DRIVE0: out_d[i] = 1'b0;

                // uart and usb status
                SEL_RS485_EN: out_d[i] = uart_tx_busy;
                SEL_POWER_ON_N: out_d[i] = power_on_n;

                // activity leds and suspend
                SEL_TX_LED_N: out_d[i] = led_n[0];
                SEL_RX_LED_N: out_d[i] = led_n[1];
                SEL_ANY_LED_N: out_d[i] = led_n[2];
                SEL_SUSPEND_N: out_d[i] = !usb_suspended;

                // divided clocks
                SEL_CLK_FAST: out_d[i] = clk_bus.clock_out_fast;
                SEL_CLK_MID: out_d[i] = clk_bus.clock_out_mid;
                SEL_CLK_SLOW: out_d[i] = clk_bus.clock_out_slow;

                // host lines, charger and strobes
                SEL_GPIO:
                begin
                    // host drives or reads the pin
                    out_d[i] = gpio_out[i];
                    oe_n_d[i] = !gpio_drive[i];
                end
                SEL_CHARGER: out_d[i] = charger_detected;
                SEL_CHARGER_N: out_d[i] = !charger_detected;
                SEL_WR_STROBE_N: out_d[i] = parallel_write_strobe_n;
                SEL_RD_STROBE_N: out_d[i] = parallel_read_strobe_n;

                // sense inputs and time stamp
                SEL_BUS_POWER: oe_n_d[i] = 1'b1; // input only
                SEL_TIME_STAMP: out_d[i] = stamp_q;
                SEL_KEEP_AWAKE_N: oe_n_d[i] = 1'b1; // input only
                default: oe_n_d[i] = 1'b1; // unknown code stays off
            endcase
        end
    end

    // ==========================================================
    // sensed inputs
    // ==========================================================
    logic sense_any; // some pin selected as bus power sense
    logic sense_hi; // a sense pin reads high
    logic awake_lo; // a keep-awake pin reads low

    // gather the input-type selections
    always_comb
    begin
        sense_any = 1'b0;
        sense_hi = 1'b0;
        awake_lo = 1'b0;
        for (int i = 0; i < PIN_N; i++)
        begin
            if (sel[i] == SEL_BUS_POWER)
            begin
                sense_any = 1'b1;
                sense_hi = sense_hi | pin_s2_q[i];
            end
            if (sel[i] == SEL_KEEP_AWAKE_N)
            begin
                awake_lo = awake_lo | !pin_s2_q[i];
            end
        end
    end

    // ==========================================================
    // output registers
    // ==========================================================
    // pad level, low during reset
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            config_bus_pin_out <= PINS_LOW;
        end
        else
        begin
            config_bus_pin_out <= out_d;
        end
    end

    // pads undriven during reset
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            config_bus_pin_oe_n <= PINS_UNDRIVEN_N;
        end
        else
        begin
            config_bus_pin_oe_n <= oe_n_d;
        end
    end

    // synchronised pad levels for the host
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            gpio_in <= PINS_LOW;
        end
        else
        begin
            gpio_in <= pin_s2_q;
        end
    end

    // bus power assumed present with no sense pin
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            bus_power_sense_in <= 1'b1;
        end
        else
        begin
            bus_power_sense_in <= !sense_any || sense_hi;
        end
    end

    // keep-awake request, idle high
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            keep_awake_n <= 1'b1;
        end
        else
        begin
            keep_awake_n <= !awake_lo;
        end
    end

endmodule : cbm_pin_mux

// ---- design/cbm_pkg.sv ----
// ==========================================================
// shared constants of the configurable pin function mux
// ==========================================================
package cbm_pkg;

    // pin count and selection code width
    localparam int PIN_N = 4;
    localparam int SEL_W = 5;

    // function selection codes held in configuration memory
    localparam logic [SEL_W-1:0] SEL_TRISTATE = 5'h00;
    localparam logic [SEL_W-1:0] SEL_DRIVE1 = 5'h01;
    localparam logic [SEL_W-1:0] SEL_DRIVE0 = 5'h02;
    localparam logic [SEL_W-1:0] SEL_RS485_EN = 5'h03;
    localparam logic [SEL_W-1:0] SEL_POWER_ON_N = 5'h04;
    localparam logic [SEL_W-1:0] SEL_TX_LED_N = 5'h05;
    localparam logic [SEL_W-1:0] SEL_RX_LED_N = 5'h06;
    localparam logic [SEL_W-1:0] SEL_ANY_LED_N = 5'h07;
    localparam logic [SEL_W-1:0] SEL_SUSPEND_N = 5'h08;
    localparam logic [SEL_W-1:0] SEL_CLK_FAST = 5'h09;
    localparam logic [SEL_W-1:0] SEL_CLK_MID = 5'h0a;
    localparam logic [SEL_W-1:0] SEL_CLK_SLOW = 5'h0b;
    localparam logic [SEL_W-1:0] SEL_GPIO = 5'h0c;
    localparam logic [SEL_W-1:0] SEL_CHARGER = 5'h0d;
    localparam logic [SEL_W-1:0] SEL_CHARGER_N = 5'h0e;
    localparam logic [SEL_W-1:0] SEL_WR_STROBE_N = 5'h0f;
    localparam logic [SEL_W-1:0] SEL_RD_STROBE_N = 5'h10;
    localparam logic [SEL_W-1:0] SEL_BUS_POWER = 5'h11;
    localparam logic [SEL_W-1:0] SEL_TIME_STAMP = 5'h12;
    localparam logic [SEL_W-1:0] SEL_KEEP_AWAKE_N = 5'h13;

    // selections used while configuration memory is not loaded
    localparam logic [SEL_W-1:0] DEF_SEL_0 = SEL_RS485_EN;
    localparam logic [SEL_W-1:0] DEF_SEL_1 = SEL_RX_LED_N;
    localparam logic [SEL_W-1:0] DEF_SEL_2 = SEL_TX_LED_N;
    localparam logic [SEL_W-1:0] DEF_SEL_3 = SEL_SUSPEND_N;

    // system clock and clock output frequencies
    localparam longint CLK_HZ = 125_000_000;
    localparam longint FAST_HZ = 24_000_000;
    localparam longint MID_HZ = 12_000_000;
    localparam longint SLOW_HZ = 6_000_000;

    // phase accumulator: one toggle per wrap, two toggles per output period
    localparam int ACC_W = 16;
    localparam logic [ACC_W-1:0] FAST_INC = ACC_W'((2 * FAST_HZ * (64'd1 << ACC_W)) / CLK_HZ);
    localparam logic [ACC_W-1:0] MID_INC = ACC_W'((2 * MID_HZ * (64'd1 << ACC_W)) / CLK_HZ);
    localparam logic [ACC_W-1:0] SLOW_INC = ACC_W'((2 * SLOW_HZ * (64'd1 << ACC_W)) / CLK_HZ);

    // activity led stretch time and its cycle count
    localparam longint LED_HOLD_NS = 1_000_000;
    localparam int LED_HOLD_CYC = int'((LED_HOLD_NS * CLK_HZ) / 64'd1_000_000_000);

    // reset values
    localparam logic [PIN_N-1:0] PINS_UNDRIVEN_N = 4'hf;
    localparam logic [PIN_N-1:0] PINS_LOW = 4'h0;

endpackage : cbm_pkg

// ---- design/cbm_clk_if.sv ----
`timescale 1ns/1ps
// ==========================================================
// carrier of the divided clock levels
// ==========================================================
interface cbm_clk_if;
    logic run; // clocks run while high
    logic clock_out_fast; // 24 MHz level
    logic clock_out_mid; // 12 MHz level
    logic clock_out_slow; // 6 MHz level

    // generator side
    modport gen (input run, output clock_out_fast, output clock_out_mid, output clock_out_slow);
    // user side
    modport user (output run, input clock_out_fast, input clock_out_mid, input clock_out_slow);
endinterface : cbm_clk_if

// ---- design/cbm_clk_gen.sv ----
`timescale 1ns/1ps
// ==========================================================
// phase accumulator clock generator, three rates
// ==========================================================
module cbm_clk_gen
    import cbm_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // clock levels
    cbm_clk_if.gen clk_bus
);

    localparam int N = 3;
    // per-rate increment
    localparam logic [N-1:0][ACC_W-1:0] INC = {SLOW_INC, MID_INC, FAST_INC};

    logic [N-1:0][ACC_W-1:0] acc_q; // phase accumulators
    logic [N-1:0] lvl_q; // output levels

    // accumulate; a carry out toggles the level; stopped clocks sit low
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            acc_q <= '0;
            lvl_q <= '0;
        end
        else if (!clk_bus.run)
        begin
            acc_q <= '0;
            lvl_q <= '0;
        end
        else
        begin
            for (int i = 0; i < N; i++)
            begin
                acc_q[i] <= acc_q[i] + INC[i];
                if ((({1'b0, acc_q[i]} + {1'b0, INC[i]}) >> ACC_W) != '0)
                begin
                    lvl_q[i] <= ~lvl_q[i];
                end
            end
        end
    end

    assign clk_bus.clock_out_fast = lvl_q[0];
    assign clk_bus.clock_out_mid = lvl_q[1];
    assign clk_bus.clock_out_slow = lvl_q[2];

endmodule : cbm_clk_gen

// ---- tb/cbm_pin_mux_properties.sv ----
`timescale 1ns/1ps
// ==========================================================
// port checker of the pin function mux, watching pin 0
// ==========================================================
module cbm_pin_mux_properties
    import cbm_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // selection and sources
    input wire logic config_valid,
    input wire logic [PIN_N-1:0][SEL_W-1:0] config_nvm_sel,
    input wire logic uart_tx_busy,
    input wire logic usb_configured,
    input wire logic usb_suspended,
    input wire logic usb_tx_active,
    input wire logic usb_sof_pulse,
    input wire logic parallel_write_strobe_n,
    // pad driver
    input wire logic [PIN_N-1:0] config_bus_pin_out,
    input wire logic [PIN_N-1:0] config_bus_pin_oe_n
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    logic [SEL_W-1:0] sel0; // selection in force on pin 0
    logic out0; // pin 0 level
    logic off0; // pin 0 driver off
    assign sel0 = config_valid ? config_nvm_sel[0] : DEF_SEL_0;
    assign out0 = config_bus_pin_out[0];
    assign off0 = config_bus_pin_oe_n[0];
    a_tristate_off: assert property (sel0 == SEL_TRISTATE |=> off0)
        else $error("tristate pin driven");
    a_drive_high: assert property (sel0 == SEL_DRIVE1 |=> !off0 && out0)
        else $error("constant high missing");
    a_rs485_copy: assert property (sel0 == SEL_RS485_EN |=> !off0 && out0 == $past(uart_tx_busy))
        else $error("rs485 enable wrong");
    a_power_level: assert property (sel0 == SEL_POWER_ON_N |=>
        out0 == !($past(usb_configured) && !$past(usb_suspended)))
        else $error("power indicator wrong");
    a_tx_led_lit: assert property (sel0 == SEL_TX_LED_N && usb_tx_active |=> !out0)
        else $error("tx led not lit");
    a_suspend_level: assert property (sel0 == SEL_SUSPEND_N |=> out0 == !$past(usb_suspended))
        else $error("suspend indicator wrong");
    a_write_strobe: assert property (sel0 == SEL_WR_STROBE_N |=> out0 == $past(parallel_write_strobe_n))
        else $error("write strobe not copied");
    a_sense_undriven: assert property (sel0 == SEL_BUS_POWER || sel0 == SEL_KEEP_AWAKE_N |=> off0)
        else $error("input pin driven");
    a_clock_frozen: assert property ((sel0 == SEL_CLK_FAST && usb_suspended) [*3] |=> !out0)
        else $error("clock runs in suspend");
    a_stamp_toggle: assert property ((sel0 == SEL_TIME_STAMP && usb_sof_pulse) ##1
        (sel0 == SEL_TIME_STAMP && !usb_sof_pulse) [*2] |=> out0 != $past(out0, 3))
        else $error("time stamp not toggled");
endmodule : cbm_pin_mux_properties

bind cbm_pin_mux cbm_pin_mux_properties chk_u (.clock(clock), .rst_b(rst_b), .config_valid(config_valid),
    .config_nvm_sel(config_nvm_sel), .uart_tx_busy(uart_tx_busy), .usb_configured(usb_configured),
    .usb_suspended(usb_suspended), .usb_tx_active(usb_tx_active), .usb_sof_pulse(usb_sof_pulse),
    .parallel_write_strobe_n(parallel_write_strobe_n), .config_bus_pin_out(config_bus_pin_out),
    .config_bus_pin_oe_n(config_bus_pin_oe_n));

// ---- tb/cbm_board_model.sv ----
`timescale 1ns/1ps
// ==========================================================
// board side of the pads: pull-ups and external drivers
// ==========================================================
module cbm_board_model
    import cbm_pkg::*;
(
    // device pad driver
    input wire logic [PIN_N-1:0] pin_out,
    input wire logic [PIN_N-1:0] pin_oe_n,
    // board drivers
    input wire logic [PIN_N-1:0] ext_drive,
    input wire logic [PIN_N-1:0] ext_level,
    // suspend pull-down option
    input wire logic pull_down_en,
    input wire logic suspended,
    // resolved pad level
    output logic [PIN_N-1:0] pad_level
);
    // x when device and board both drive, else device, then board driver, then weak pull
    always_comb
    begin
        for (int i = 0; i < PIN_N; i++)
        begin
            if (!pin_oe_n[i] && ext_drive[i])
                pad_level[i] = 1'bx; // contention
            else if (!pin_oe_n[i])
                pad_level[i] = pin_out[i];
            else if (ext_drive[i])
                pad_level[i] = ext_level[i];
            else
                pad_level[i] = !(pull_down_en && suspended);
        end
    end
endmodule : cbm_board_model

// ---- tb/test_config_bus_pin_function_mux.sv ----
`timescale 1ns/1ps
// ==========================================================
// self-checking bench of the pin function mux
// ==========================================================
module test_config_bus_pin_function_mux
    import cbm_pkg::*;
;
    localparam int HOLD = 8; // short led stretch
    logic clock = 1'b0, rst_b = 1'b0, config_valid = 1'b0;
    logic [PIN_N-1:0][SEL_W-1:0] config_nvm_sel = '0;
    logic uart_tx_busy = 1'b0, usb_configured = 1'b0, usb_suspended = 1'b0;
    logic usb_tx_active = 1'b0, usb_rx_active = 1'b0, usb_sof_pulse = 1'b0, charger_detected = 1'b0;
    logic parallel_write_strobe_n = 1'b1, parallel_read_strobe_n = 1'b1;
    logic [PIN_N-1:0] gpio_out = '0, gpio_drive = '0, ext_drive = '0, ext_level = '0;
    logic [PIN_N-1:0] pad_level, config_bus_pin_out, config_bus_pin_oe_n, gpio_in;
    logic bus_power_sense_in, keep_awake_n;
    int miscompares = 0, tests_run = 0;
    always #4 clock = ~clock;
    cbm_pin_mux #(.LED_HOLD(HOLD)) dut_u (.clock(clock), .rst_b(rst_b), .config_valid(config_valid),
        .config_nvm_sel(config_nvm_sel), .uart_tx_busy(uart_tx_busy), .usb_configured(usb_configured),
        .usb_suspended(usb_suspended), .usb_tx_active(usb_tx_active), .usb_rx_active(usb_rx_active),
        .usb_sof_pulse(usb_sof_pulse), .charger_detected(charger_detected),
        .parallel_write_strobe_n(parallel_write_strobe_n), .parallel_read_strobe_n(parallel_read_strobe_n),
        .gpio_out(gpio_out), .gpio_drive(gpio_drive), .config_bus_pin_in(pad_level),
        .config_bus_pin_out(config_bus_pin_out), .config_bus_pin_oe_n(config_bus_pin_oe_n), .gpio_in(gpio_in),
        .bus_power_sense_in(bus_power_sense_in), .keep_awake_n(keep_awake_n));
    cbm_board_model board_u (.pin_out(config_bus_pin_out), .pin_oe_n(config_bus_pin_oe_n),
        .ext_drive(ext_drive), .ext_level(ext_level), .pull_down_en(1'b0), .suspended(usb_suspended),
        .pad_level(pad_level));
    // ==========================================================
    // helpers
    // ==========================================================
    task step(int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : step
    task chk4(logic [3:0] got, logic [3:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk4
    task chk_cnt(int got, int exp);
        tests_run++;
        if (got < exp - 2 || got > exp + 2)
        begin
            miscompares++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_cnt
    // expected {driver off, level} of one pin for the steady options
    function automatic logic [1:0] exp_pin(logic [SEL_W-1:0] c, int p);
        case (c)
            SEL_DRIVE1: return 2'b01;
            SEL_DRIVE0: return 2'b00;
            SEL_RS485_EN: return {1'b0, uart_tx_busy};
            SEL_POWER_ON_N: return {1'b0, !(usb_configured && !usb_suspended)};
            SEL_TX_LED_N, SEL_RX_LED_N, SEL_ANY_LED_N: return 2'b01;
            SEL_SUSPEND_N: return {1'b0, !usb_suspended};
            SEL_GPIO: return {!gpio_drive[p], gpio_out[p] && gpio_drive[p]};
            SEL_CHARGER: return {1'b0, charger_detected};
            SEL_CHARGER_N: return {1'b0, !charger_detected};
            SEL_WR_STROBE_N: return {1'b0, parallel_write_strobe_n};
            SEL_RD_STROBE_N: return {1'b0, parallel_read_strobe_n};
            default: return 2'b10; // tristate, inputs, unknown codes
        endcase
    endfunction : exp_pin
    // ==========================================================
    // scenarios
    // ==========================================================
    task t_defaults;
        @(posedge clock);
        uart_tx_busy <= 1'b1;
        usb_suspended <= 1'b1;
        usb_rx_active <= 1'b1;
        step(3);
        chk4(config_bus_pin_out, 4'h5);
        chk4(config_bus_pin_oe_n, 4'h0);
        @(posedge clock);
        usb_rx_active <= 1'b0;
    endtask : t_defaults
    task t_table;
        logic [SEL_W-1:0] c;
        logic [1:0] e;
        logic [PIN_N-1:0] lvl;
        for (int k = 0; k < 4; k++)
        begin
            for (int n = 0; n < 21; n++)
            begin
                c = (n == 20) ? 5'h1f : SEL_W'(n);
                if (c inside {SEL_CLK_FAST, SEL_CLK_MID, SEL_CLK_SLOW, SEL_TIME_STAMP})
                    continue;
                @(posedge clock);
                config_valid <= 1'b1;
                config_nvm_sel <= {PIN_N{c}};
                uart_tx_busy <= k[0];
                usb_configured <= k[1];
                usb_suspended <= k[0] ^ k[1];
                charger_detected <= k[1];
                parallel_write_strobe_n <= k[0];
                parallel_read_strobe_n <= !k[0];
                gpio_out <= k[1] ? 4'h5 : 4'ha;
                gpio_drive <= k[0] ? 4'h3 : 4'hc;
                step(5);
                for (int p = 0; p < PIN_N; p++)
                begin
                    e = exp_pin(c, p);
                    lvl[p] = e[1] | e[0];
                    chk4({2'h0, config_bus_pin_oe_n[p], config_bus_pin_out[p] & !config_bus_pin_oe_n[p]},
                        {2'h0, e});
                end
                chk4(gpio_in, lvl);
            end
        end
    endtask : t_table
    task t_sense;
        @(posedge clock);
        config_nvm_sel <= {PIN_N{SEL_BUS_POWER}};
        ext_drive <= 4'hf;
        step(5);
        chk4({3'h0, bus_power_sense_in}, 4'h0);
        @(posedge clock);
        ext_level <= 4'h4;
        step(5);
        chk4({3'h0, bus_power_sense_in}, 4'h1);
        @(posedge clock);
        config_nvm_sel <= {PIN_N{SEL_KEEP_AWAKE_N}};
        step(5);
        chk4({3'h0, keep_awake_n}, 4'h0);
        @(posedge clock);
        ext_level <= 4'hf;
        step(5);
        chk4({2'h0, keep_awake_n, bus_power_sense_in}, 4'h3);
        @(posedge clock);
        ext_drive <= 4'h0;
    endtask : t_sense
    task t_leds;
        @(posedge clock);
        config_nvm_sel <= {SEL_SUSPEND_N, SEL_ANY_LED_N, SEL_RX_LED_N, SEL_TX_LED_N};
        usb_suspended <= 1'b0;
        usb_tx_active <= 1'b1;
        step(3);
        chk4(config_bus_pin_out, 4'ha);
        @(posedge clock);
        usb_tx_active <= 1'b0;
        step(HOLD / 2);
        chk4(config_bus_pin_out, 4'ha);
        step(HOLD + 2);
        chk4(config_bus_pin_out, 4'hf);
        @(posedge clock);
        usb_rx_active <= 1'b1;
        step(3);
        chk4(config_bus_pin_out, 4'h9);
        @(posedge clock);
        usb_rx_active <= 1'b0;
        step(HOLD + 4);
        chk4(config_bus_pin_out, 4'hf);
    endtask : t_leds
    task t_clocks;
        int n [PIN_N];
        logic [PIN_N-1:0] last;
        @(posedge clock);
        config_nvm_sel <= {SEL_CLK_FAST, SEL_CLK_SLOW, SEL_CLK_MID, SEL_CLK_FAST};
        step(4);
        n = '{default: 0};
        last = config_bus_pin_out;
        repeat (1000)
        begin
            step(1);
            for (int p = 0; p < PIN_N; p++)
                n[p] += int'(config_bus_pin_out[p] != last[p]);
            last = config_bus_pin_out;
        end
        chk_cnt(n[0], int'(2 * FAST_HZ * 1000 / CLK_HZ));
        chk_cnt(n[1], int'(2 * MID_HZ * 1000 / CLK_HZ));
        chk_cnt(n[2], int'(2 * SLOW_HZ * 1000 / CLK_HZ));
        @(posedge clock);
        usb_suspended <= 1'b1;
        step(5);
        chk4(config_bus_pin_out, 4'h0);
        step(37);
        chk4(config_bus_pin_out, 4'h0);
        @(posedge clock);
        usb_suspended <= 1'b0;
    endtask : t_clocks
    task t_stamp;
        logic [PIN_N-1:0] prev;
        @(posedge clock);
        config_nvm_sel <= {PIN_N{SEL_TIME_STAMP}};
        step(4);
        repeat (2)
        begin
            prev = config_bus_pin_out;
            @(posedge clock);
            usb_sof_pulse <= 1'b1;
            @(posedge clock);
            usb_sof_pulse <= 1'b0;
            step(4);
            chk4(config_bus_pin_out, ~prev);
        end
    endtask : t_stamp
    // ==========================================================
    // verdict and run control
    // ==========================================================
    task end_of_test;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_of_test
    // watchdog well beyond the roughly 1560 cycles of the run
    initial
    begin
        repeat (20000) @(posedge clock);
        miscompares++;
        end_of_test();
    end
    // main sequence: reset held for 16 cycles, then the scenarios
    initial
    begin
        repeat (16) @(posedge clock);
        rst_b <= 1'b1;
        step(2);
        t_defaults();
        t_table();
        t_sense();
        t_leds();
        t_clocks();
        t_stamp();
        end_of_test();
    end
endmodule : test_config_bus_pin_function_mux
